// ==== crcen_pkg.sv ====
/*
 * Shared constants for the byte-wide CRC engine: polynomials, seeds,
 * bit counts, FIFO depth and reset values; POLY32, CRC16_W, CRC32_W and SEED_RST are not used by the engine.
 * Assumes nothing of its surroundings.
 */
package crcen_pkg;
  localparam int BYTE_W = 8;
  localparam int CRC16_W = 16;
  localparam int CRC32_W = 32;
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [31:0] POLY32 = 32'h04C11DB7;
  localparam logic [31:0] POLY32_REFL = 32'hEDB88320;
  localparam logic [15:0] SEED16_ZERO = 16'h0000;
  localparam logic [15:0] SEED16_ONES = 16'hFFFF;
  localparam logic [31:0] SEED32_ZERO = 32'h00000000;
  localparam logic [31:0] SEED32_ONES = 32'hFFFFFFFF;
  localparam int BITS_PER_BYTE = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [31:0] RESULT_RST = 32'h00000000;
  localparam logic WIDTH_RST = 1'b0;
  localparam logic SEED_RST = 1'b0;
endpackage

// ==== crcen_fifo.sv ====
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module crcen_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != DEPTH_C);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wptr_nxt = (wptr_r == LAST_C) ? '0 : wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = (rptr_r == LAST_C) ? '0 : rptr_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end
endmodule

// ==== crcen_step.sv ====
/*
 * Combinational one-byte CRC update for both widths.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module crcen_step (
  input wire logic [31:0] acc_i,
  input wire logic [7:0] byte_i,
  input wire logic wide_i,
  output logic [31:0] acc_o
);
  function automatic logic [15:0] upd16(input logic [15:0] a, input logic [7:0] b);
    logic [15:0] r;
    r = a ^ {b, 8'h00}; // RQ3
    for (int i = 0; i < crcen_pkg::BITS_PER_BYTE; i++) begin
      if (r[15]) begin
        r = {r[14:0], 1'b0} ^ crcen_pkg::POLY16; // RQ4
      end else begin
        r = {r[14:0], 1'b0}; // RQ1
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] upd32(input logic [31:0] a, input logic [7:0] b);
    logic [31:0] r;
    r = a ^ {24'h000000, b}; // RQ9
    for (int i = 0; i < crcen_pkg::BITS_PER_BYTE; i++) begin
      // Reflected form: input and result reversal folded into the shift direction
      if (r[0]) begin
        r = {1'b0, r[31:1]} ^ crcen_pkg::POLY32_REFL; // RQ10
      end else begin
        r = {1'b0, r[31:1]}; // RQ7
      end
    end
    return r;
  endfunction

  always_comb begin
    if (wide_i) begin
      acc_o = upd32(acc_i, byte_i); // RQ6
    end else begin
      acc_o = {16'h0000, upd16(acc_i[15:0], byte_i)};
    end
  end
endmodule

// ==== crcen_engine.sv ====
/*
 * Byte-wide CRC engine, 16-bit MSB-first or 32-bit reflected.
 * Assumes bytes arrive by valid/ready on the system clock and that
 * software-side controls come from logic on the same clock.
 */
`timescale 1ns/1ps
// Summary of operation
// RQ1: 16-bit mode MSB-first, poly 1021
// RQ2: 16-bit seed all zeros or ones
// RQ3: Byte XORed into remainder upper byte
// RQ4: Eight left shifts, conditional poly XOR
// RQ5: 16-bit check words for known messages
// RQ6: 32-bit mode uses poly 04C11DB7
// RQ7: 32-bit mode fully bit-reflected
// RQ8: 32-bit seed all zeros or ones
// RQ9: Byte XORed into remainder low byte
// RQ10: Eight right shifts, reflected poly XOR
// RQ11: 32-bit check words for known messages
// RQ12: Init then bytes; result after each update
module crcen_engine #(
  parameter int DEPTH = crcen_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wide_i,
  input wire logic seed_ones_i,
  input wire logic init_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  output logic [31:0] result_o,
  output logic busy_o,
  output logic wide_o
);
  typedef enum logic [1:0] {
    CRCEN_IDLE = 2'b01,
    CRCEN_CALC = 2'b10
  } crcen_state_t;

  crcen_state_t state_r, state_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic wide_r, wide_nxt;
  logic [7:0] fifo_data;
  logic fifo_valid, fifo_ready, fifo_in_ready;
  logic [31:0] step_out;

  // Bytes offered during init are held off so they join the new message
  crcen_fifo #(.WIDTH(crcen_pkg::BYTE_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_data_i(byte_i),
    .in_valid_i(byte_valid_i && !init_i),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  crcen_step u_step (
    .acc_i(acc_r),
    .byte_i(fifo_data),
    .wide_i(wide_r),
    .acc_o(step_out)
  );

  assign byte_ready_o = fifo_in_ready && !init_i;
  // One byte folded per cycle; drained only in CALC
  assign fifo_ready = (state_r == CRCEN_CALC) && !init_i;

  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    wide_nxt = wide_r;
    if (init_i) begin
      wide_nxt = wide_i;
      if (wide_i) begin
        acc_nxt = seed_ones_i ? crcen_pkg::SEED32_ONES : crcen_pkg::SEED32_ZERO; // RQ8
      end else begin
        acc_nxt = {16'h0000, seed_ones_i ? crcen_pkg::SEED16_ONES
                                         : crcen_pkg::SEED16_ZERO}; // RQ2
      end
      state_nxt = CRCEN_IDLE; // RQ12
    end else begin
      case (state_r)
        CRCEN_IDLE: begin
          if (fifo_valid) begin
            state_nxt = CRCEN_CALC;
          end
        end
        CRCEN_CALC: begin
          if (fifo_valid) begin
            acc_nxt = step_out; // RQ5 RQ11
          end else begin
            state_nxt = CRCEN_IDLE;
          end
        end
        default: begin
          state_nxt = CRCEN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r <= CRCEN_IDLE;
      acc_r <= crcen_pkg::RESULT_RST;
      wide_r <= crcen_pkg::WIDTH_RST;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      wide_r <= wide_nxt;
    end
  end

  // Result valid whenever busy is low and the FIFO is empty
  assign result_o = acc_r;
  assign busy_o = fifo_valid || init_i; // RQ12
  assign wide_o = wide_r;
endmodule

// ==== crcen_engine_props.sv ====
/* Port checker for crcen_engine.
   Bound to every crcen_engine instance. */
`timescale 1ns/1ps
module crcen_engine_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wide_i,
  input wire logic seed_ones_i,
  input wire logic init_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  input wire logic byte_ready_o,
  input wire logic [31:0] result_o,
  input wire logic busy_o,
  input wire logic wide_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_rst; $rose(rstn_i) |-> result_o == 32'h0 && !wide_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_s16; init_i && !wide_i |=> result_o == {16'h0, {16{$past(seed_ones_i)}}}; endproperty
  a_s16: assert property (p_s16) else $error("bad 16-bit seed");
  property p_s32; init_i && wide_i |=> result_o == {32{$past(seed_ones_i)}}; endproperty
  a_s32: assert property (p_s32) else $error("bad 32-bit seed");
  property p_wide; init_i |=> wide_o == $past(wide_i); endproperty
  a_wide: assert property (p_wide) else $error("width not taken");
  property p_ref; init_i |-> !byte_ready_o && busy_o; endproperty
  a_ref: assert property (p_ref) else $error("byte taken during init");
  property p_top; !wide_o |-> result_o[31:16] == 16'h0; endproperty
  a_top: assert property (p_top) else $error("upper half set");
  property p_hold; !busy_o && !init_i && !byte_valid_i |=> $stable(result_o); endproperty
  a_hold: assert property (p_hold) else $error("result moved when idle");
  property p_fold;
    (byte_valid_i && byte_ready_o && !busy_o && !init_i) ##1 (!byte_valid_i && !init_i)[*3]
      |-> !busy_o;
  endproperty
  a_fold: assert property (p_fold) else $error("byte fold too slow");
endmodule
bind crcen_engine crcen_engine_props crcen_engine_props_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .wide_i(wide_i), .seed_ones_i(seed_ones_i), .init_i(init_i), .byte_i(byte_i),
  .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o), .result_o(result_o),
  .busy_o(busy_o), .wide_o(wide_o));

// ==== crcen_engine_test.sv ====
/* Self-checking bench for crcen_engine: check words, zero seeds, init refusal.
   Assumes the package and the design files are compiled first. */
`timescale 1ns/1ps
module crcen_engine_test;
  typedef struct packed {logic w; logic s; logic [2:0] n; logic [39:0] d; logic [31:0] e;} crcen_row_t;
  logic clk_i = 1'b0, rstn_i = 1'b0, wide_i = 1'b0, seed_ones_i = 1'b0, init_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic byte_valid_i = 1'b0, byte_ready_o, busy_o, wide_o;
  logic [31:0] result_o;
  int mismatches = 0, n_compared = 0;
  crcen_row_t rows [6] = '{'{1'b0, 1'b1, 3'h1, 40'h63, 32'h0000BD35},
    '{1'b0, 1'b1, 3'h3, 40'hAABBCC, 32'h00006CF6},
    '{1'b0, 1'b1, 3'h5, 40'h0000AABBCC, 32'h0000B166},
    '{1'b1, 1'b1, 3'h1, 40'h63, 32'hF9462090},
    '{1'b1, 1'b1, 3'h3, 40'hAABBCC, 32'h41B207B3},
    '{1'b1, 1'b1, 3'h5, 40'h0000AABBCC, 32'h78D129BC}};
  always #10 clk_i = ~clk_i;
  crcen_engine crcen_engine_i (.clk_i(clk_i), .rstn_i(rstn_i), .wide_i(wide_i),
    .seed_ones_i(seed_ones_i), .init_i(init_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
    .byte_ready_o(byte_ready_o), .result_o(result_o), .busy_o(busy_o), .wide_o(wide_o));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mdl(logic [31:0] a, logic [7:0] b, logic w);
    a = a ^ (w ? {24'h0, b} : {16'h0, b, 8'h0});
    for (int k = 0; k < 8; k++) begin
      if (w) a = a[0] ? (a >> 1) ^ crcen_pkg::POLY32_REFL : a >> 1;
      else a = {16'h0, a[15] ? (a[15:0] << 1) ^ crcen_pkg::POLY16 : a[15:0] << 1};
    end
    return a;
  endfunction
  task automatic run(logic w, logic s, logic [2:0] n, logic [39:0] d);
    logic [31:0] m;
    int k;
    m = w ? {32{s}} : {16'h0, {16{s}}};
    k = 0;
    @(negedge clk_i);
    wide_i = w;
    seed_ones_i = s;
    init_i = 1'b1;
    byte_i = 8'h5A;
    byte_valid_i = 1'b1;
    #1 chk({31'h0, byte_ready_o}, 32'h0);
    @(negedge clk_i);
    init_i = 1'b0;
    for (int i = 0; i < n; i++) begin
      byte_i = d[8*(n-1-i) +: 8];
      byte_valid_i = 1'b1;
      m = mdl(m, byte_i, w);
      #1 chk({31'h0, byte_ready_o}, 32'h1);
      @(negedge clk_i);
    end
    byte_valid_i = 1'b0;
    while (busy_o !== 1'b0 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 50) begin
      mismatches++;
      summarize();
    end else begin
      chk(result_o, m);
      chk({31'h0, wide_o}, {31'h0, w});
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    chk(result_o, 32'h0);
    chk({30'h0, busy_o, wide_o}, 32'h0);
    rstn_i = 1'b1;
    $display("reset done");
    for (int i = 0; i < 6; i++) begin
      run(rows[i].w, rows[i].s, rows[i].n, rows[i].d);
      chk(result_o, rows[i].e);
      $display("row %0d done", i);
    end
    run(1'b0, 1'b0, 3'h5, 40'h0000AABBCC);
    run(1'b1, 1'b0, 3'h5, 40'h0000AABBCC);
    $display("zero seeds done");
    summarize();
  end
endmodule
